/* rri_exec.v */
// Purpose: Executes return and rotate-through-carry instructions
// Assumes: Operand value of the addressed file register is supplied
// Notes:   Other instructions only advance the PC; CALL pushes via port
`timescale 1ns/100ps
`include "rri_consts.vh"
module rri_exec #(
  parameter AW    = 15,
  parameter DEPTH = 16,
  parameter PW    = 4
) (
  clk,
  rst,
  instr_valid,
  instr,
  file_rd_data,
  call_push,
  call_addr,
  busy,
  pc,
  w_reg,
  carry,
  interrupt_control_reg,
  file_wr_en,
  file_wr_addr,
  file_wr_data,
  stack_ptr
);
  input  wire          clk;
  input  wire          rst;
  input  wire          instr_valid;
  input  wire [13:0]   instr;
  input  wire [7:0]    file_rd_data;
  input  wire          call_push;
  input  wire [AW-1:0] call_addr;
  output wire          busy;
  output wire [AW-1:0] pc;
  output wire [7:0]    w_reg;
  output wire          carry;
  output wire [7:0]    interrupt_control_reg;
  output wire          file_wr_en;
  output wire [6:0]    file_wr_addr;
  output wire [7:0]    file_wr_data;
  output wire [PW-1:0] stack_ptr;

  // Instruction classes
  localparam OP_OTHER     = 3'h0;
  localparam OP_RET       = 3'h1;
  localparam OP_RET_IRQ   = 3'h2;
  localparam OP_RET_LIT   = 3'h3;
  localparam OP_ROT_LEFT  = 3'h4;
  localparam OP_ROT_RIGHT = 3'h5;
  localparam [AW-1:0] PC_STEP = {{(AW-1){1'b0}}, 1'b1};

  wire [AW-1:0] top_of_stack;
  wire          take;
  wire          do_pop;
  wire          do_push;
  wire [7:0]    rot_l;
  wire [7:0]    rot_r;
  reg  [2:0]    op_class;
  reg  [7:0]    rot_res;
  reg           rot_c;
  reg  [1:0]    cyc_r;
  reg  [1:0]    cyc_nxt;
  reg  [AW-1:0] pc_r;
  reg  [AW-1:0] pc_nxt;
  reg  [7:0]    w_r;
  reg  [7:0]    w_nxt;
  reg           carry_r;
  reg           carry_nxt;
  reg  [7:0]    irq_ctrl_r;
  reg  [7:0]    irq_ctrl_nxt;
  reg           wr_en_r;
  reg           wr_en_nxt;
  reg  [6:0]    wr_addr_r;
  reg  [6:0]    wr_addr_nxt;
  reg  [7:0]    wr_data_r;
  reg  [7:0]    wr_data_nxt;

  // Second return cycle refuses new work
  assign busy   = (cyc_r != 2'h0);
  assign take   = instr_valid & ~busy;
  assign do_pop = take & ((op_class == OP_RET) |
                          (op_class == OP_RET_IRQ) |
                          (op_class == OP_RET_LIT));
  // A pop wins over a call push in the same cycle
  assign do_push = call_push & ~do_pop;

  // Opcode decode
  always @* begin
    op_class = OP_OTHER;
    case (instr[13:8])
      `RRI_OP_SYS_HI: begin
        if (instr == `RRI_OP_RETURN) begin
          op_class = OP_RET;
        end else if (instr == `RRI_OP_RET_IRQ) begin
          op_class = OP_RET_IRQ;
        end
      end
      `RRI_OP_RET_LIT_HI: begin
        op_class = OP_RET_LIT;
      end
      `RRI_OP_ROT_LEFT_HI: begin
        op_class = OP_ROT_LEFT;
      end
      `RRI_OP_ROT_RIGHT_HI: begin
        op_class = OP_ROT_RIGHT;
      end
      default: begin
        op_class = OP_OTHER;
      end
    endcase
  end

  assign rot_l = {file_rd_data[6:0], carry_r};
  assign rot_r = {carry_r, file_rd_data[7:1]};

  // Rotate result and outgoing carry
  always @* begin
    rot_res = rot_l;
    rot_c   = file_rd_data[7];
    if (op_class == OP_ROT_RIGHT) begin
      rot_res = rot_r;
      rot_c   = file_rd_data[0];
    end
  end

  rri_stack #(
    .AW    (AW),
    .DEPTH (DEPTH),
    .PW    (PW)
  ) u_stack (
    .clk          (clk),
    .rst          (rst),
    .push         (do_push),
    .pop          (do_pop),
    .push_data    (call_addr),
    .top_of_stack (top_of_stack),
    .stack_ptr    (stack_ptr)
  );

  // Next state of the core registers
  always @* begin
    cyc_nxt      = cyc_r;
    pc_nxt       = pc_r;
    w_nxt        = w_r;
    carry_nxt    = carry_r;
    irq_ctrl_nxt = irq_ctrl_r;
    wr_en_nxt    = 1'b0;
    wr_addr_nxt  = wr_addr_r;
    wr_data_nxt  = wr_data_r;
    if (busy) begin
      cyc_nxt = cyc_r - 2'h1;
    end else if (take) begin
      pc_nxt = pc_r + PC_STEP;
      if (do_pop) begin
        cyc_nxt = `RRI_RET_CYCLES - 2'h1;
        pc_nxt  = top_of_stack;
      end
      case (op_class)
        OP_RET_IRQ: begin
          irq_ctrl_nxt[`RRI_IRQ_ENABLE_BIT] = 1'b1;
        end
        OP_RET_LIT: begin
          w_nxt = instr[7:0];
        end
        OP_ROT_LEFT, OP_ROT_RIGHT: begin
          carry_nxt = rot_c;
          if (instr[7]) begin
            wr_en_nxt   = 1'b1;
            wr_addr_nxt = instr[6:0];
            wr_data_nxt = rot_res;
          end else begin
            w_nxt = rot_res;
          end
        end
        default: begin
          carry_nxt = carry_r;
        end
      endcase
    end
  end

  // State registers, synchronous reset
  always @(posedge clk) begin
    if (rst) begin
      cyc_r      <= 2'h0;
      pc_r       <= `RRI_PC_RESET;
      w_r        <= 8'h00;
      carry_r    <= 1'b0;
      irq_ctrl_r <= `RRI_IRQ_CTRL_RESET;
      wr_en_r    <= 1'b0;
      wr_addr_r  <= 7'h00;
      wr_data_r  <= 8'h00;
    end else begin
      cyc_r      <= cyc_nxt;
      pc_r       <= pc_nxt;
      w_r        <= w_nxt;
      carry_r    <= carry_nxt;
      irq_ctrl_r <= irq_ctrl_nxt;
      wr_en_r    <= wr_en_nxt;
      wr_addr_r  <= wr_addr_nxt;
      wr_data_r  <= wr_data_nxt;
    end
  end

  // Outputs straight from flops
  assign pc                    = pc_r;
  assign w_reg                 = w_r;
  assign carry                 = carry_r;
  assign interrupt_control_reg = irq_ctrl_r;
  assign file_wr_en            = wr_en_r;
  assign file_wr_addr          = wr_addr_r;
  assign file_wr_data          = wr_data_r;

endmodule // rri_exec

/* rri_consts.vh */
// Purpose: Constants for the return and rotate execution unit
// Assumes: 14-bit instruction words, 15-bit program counter
// Notes:   Plain and interrupt return opcodes are 14-bit codes, others 6-bit high fields, destination in bit 7
// Functional notes
// - Interrupt return pops stack into PC
// - Interrupt return sets global enable bit 7
// - Returns take one word, two cycles
// - Plain return pops stack, flags untouched
// - Literal return loads W, flags untouched
// - Literal return reloads PC from stack
// - Rotate left through carry, only carry
// - Rotate right through carry, only carry
// - Destination bit selects W or file
`ifndef RRI_CONSTS_VH
`define RRI_CONSTS_VH
`define RRI_OP_RETURN        14'h0008
`define RRI_OP_RET_IRQ       14'h0009
`define RRI_OP_SYS_HI        6'h00
`define RRI_OP_RET_LIT_HI    6'h34
`define RRI_OP_ROT_LEFT_HI   6'h0d
`define RRI_OP_ROT_RIGHT_HI  6'h0c
`define RRI_IRQ_ENABLE_BIT   7
`define RRI_RET_CYCLES       2'h2
`define RRI_PC_RESET         15'h0000
`define RRI_IRQ_CTRL_RESET   8'h00
`endif

/* rri_stack.v */
// Purpose: Hardware return stack with pointer
// Assumes: Push and pop never requested together
// Notes:   Top entry read data come from a register
`timescale 1ns/100ps
module rri_stack #(
  parameter AW    = 15,
  parameter DEPTH = 16,
  parameter PW    = 4
) (
  clk,
  rst,
  push,
  pop,
  push_data,
  top_of_stack,
  stack_ptr
);
  input  wire          clk;
  input  wire          rst;
  input  wire          push;
  input  wire          pop;
  input  wire [AW-1:0] push_data;
  output reg  [AW-1:0] top_of_stack;
  output reg  [PW-1:0] stack_ptr;

  reg [AW-1:0] mem [0:DEPTH-1];
  wire [PW-1:0] ptr_dec;
  wire [PW-1:0] ptr_inc;
  assign ptr_dec = stack_ptr - {{(PW-1){1'b0}}, 1'b1};
  assign ptr_inc = stack_ptr + {{(PW-1){1'b0}}, 1'b1};

  always @(posedge clk) begin
    if (push) begin
      mem[stack_ptr] <= push_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      stack_ptr    <= {PW{1'b1}};
      top_of_stack <= {AW{1'b0}};
    end else if (push) begin
      stack_ptr    <= ptr_inc;
      top_of_stack <= push_data;
    end else if (pop) begin
      stack_ptr    <= ptr_dec;
      top_of_stack <= mem[ptr_dec - {{(PW-1){1'b0}}, 1'b1}];
    end
  end
endmodule // rri_stack

/* rri_exec_sva.sv */
// Purpose: Checker for rri_exec
// Assumes: Port view only
// Notes:   Bound below
`timescale 1ns/100ps
`include "rri_consts.vh"
module rri_exec_sva #(parameter PW = 4) (
  input wire          clk,
  input wire          rst,
  input wire          instr_valid,
  input wire [13:0]   instr,
  input wire [7:0]    file_rd_data,
  input wire          busy,
  input wire [7:0]    w_reg,
  input wire          carry,
  input wire [7:0]    interrupt_control_reg,
  input wire          file_wr_en,
  input wire [6:0]    file_wr_addr,
  input wire [PW-1:0] stack_ptr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire tk  = instr_valid & ~busy;
  wire rfi = tk & (instr == `RRI_OP_RET_IRQ);
  wire ret = tk & (instr == `RRI_OP_RETURN);
  wire rlw = tk & (instr[13:8] == `RRI_OP_RET_LIT_HI);
  wire rl  = tk & (instr[13:8] == `RRI_OP_ROT_LEFT_HI);
  wire rr  = tk & (instr[13:8] == `RRI_OP_ROT_RIGHT_HI);
  property p_pop; rfi |=> stack_ptr == $past(stack_ptr) - 1'b1; endproperty
  a_pop: assert property (p_pop) else $error("no pop");
  property p_gie; rfi |=> interrupt_control_reg[7]; endproperty
  a_gie: assert property (p_gie) else $error("irq enable");
  property p_two; (rfi | ret | rlw) |=> busy ##1 !busy; endproperty
  a_two: assert property (p_two) else $error("cycles");
  property p_ret; ret |=> $stable(carry) && $stable(interrupt_control_reg); endproperty
  a_ret: assert property (p_ret) else $error("flags");
  property p_lw; rlw |=> w_reg == $past(instr[7:0]) && $stable(carry); endproperty
  a_lw: assert property (p_lw) else $error("literal");
  property p_rl; rl |=> carry == $past(file_rd_data[7]); endproperty
  a_rl: assert property (p_rl) else $error("left");
  property p_rr; rr |=> carry == $past(file_rd_data[0]); endproperty
  a_rr: assert property (p_rr) else $error("right");
  property p_d; (rl | rr) |=> file_wr_en == $past(instr[7]); endproperty
  a_d: assert property (p_d) else $error("dest");
  property p_da; (rl | rr) && instr[7] |=> file_wr_addr == $past(instr[6:0]); endproperty
  a_da: assert property (p_da) else $error("addr");
endmodule // rri_exec_sva
bind rri_exec rri_exec_sva #(.PW(PW)) u_sva (.clk(clk), .rst(rst), .instr_valid(instr_valid),
  .instr(instr), .file_rd_data(file_rd_data), .busy(busy), .w_reg(w_reg), .carry(carry),
  .interrupt_control_reg(interrupt_control_reg), .file_wr_en(file_wr_en),
  .file_wr_addr(file_wr_addr), .stack_ptr(stack_ptr));

/* tb_return_and_rotate_instructions.sv */
// Purpose: Bench for rri_exec
// Assumes: Seed 55
// Notes:   Stack modelled here
`timescale 1ns/100ps
`include "rri_consts.vh"
module tb_return_and_rotate_instructions;
  reg         clk, rst, instr_valid, call_push, ec, lf;
  reg  [13:0] instr;
  reg  [7:0]  file_rd_data, res;
  reg  [14:0] call_addr, stk [0:3];
  reg  [3:0]  sp;
  reg  [31:0] s, r;
  wire        busy, carry, file_wr_en;
  wire [14:0] pc;
  wire [7:0]  w_reg, interrupt_control_reg, file_wr_data;
  wire [6:0]  file_wr_addr;
  wire [3:0]  stack_ptr;
  integer     n_fail, comparisons, cyc, i;
  rri_exec u_rri_exec (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .file_rd_data(file_rd_data), .call_push(call_push), .call_addr(call_addr), .busy(busy),
    .pc(pc), .w_reg(w_reg), .carry(carry), .interrupt_control_reg(interrupt_control_reg),
    .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .stack_ptr(stack_ptr));
  function [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    xs = s;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  task complete_run;
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task op(input [13:0] o, input [7:0] f);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= o;
    file_rd_data <= f;
    @(posedge clk);
    instr_valid <= 1'b0;
    file_rd_data <= ~f;
    #1;
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  initial begin
    {instr_valid, call_push, instr, file_rd_data, call_addr} = 39'h0;
    rst = 1'b1;
    {s, sp, ec, n_fail, comparisons, cyc} = {32'd55, 4'hf, 1'b0, 96'd0};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      r = xs();
      sp = sp + 1;
      stk[sp[1:0]] = r[14:0];
      @(posedge clk);
      call_push <= 1'b1;
      call_addr <= r[14:0];
      @(posedge clk);
      call_push <= 1'b0;
    end
    for (i = 0; i < 3; i = i + 1) begin
      r = xs();
      if (i == 0) chk(interrupt_control_reg[7], 1'b0);
      op(i == 0 ? {`RRI_OP_RET_LIT_HI, r[7:0]} : i == 1 ? `RRI_OP_RET_IRQ : `RRI_OP_RETURN,
        8'h00);
      chk(pc, stk[sp[1:0]]);
      sp = sp - 1;
      chk(stack_ptr, sp);
      chk({busy, carry}, {1'b1, ec});
      if (i == 0) chk(w_reg, r[7:0]);
      if (i == 1) chk(interrupt_control_reg[7], 1'b1);
    end
    for (i = 0; i < 40; i = i + 1) begin
      r = xs();
      lf = r[9];
      res = lf ? {r[6:0], ec} : {ec, r[7:1]};
      op({lf ? `RRI_OP_ROT_LEFT_HI : `RRI_OP_ROT_RIGHT_HI, r[8], r[16:10]}, r[7:0]);
      ec = lf ? r[7] : r[0];
      chk(carry, ec);
      chk(r[8] ? file_wr_data : w_reg, res);
      chk(file_wr_en, r[8]);
      if (r[8]) chk(file_wr_addr, r[16:10]);
    end
    complete_run;
  end
endmodule // tb_return_and_rotate_instructions
